// [logic/lsd_pkg.sv]
// Constants, types and gain arithmetic shared by the LED sink driver control logic.
package lsd_pkg;

    localparam int              LSD_CHANNELS     = 16;
    localparam int              LSD_CFG_BAND_BIT = 1;
    localparam int              LSD_CFG_MANT_LO  = 2;
    localparam int              LSD_CFG_MANT_HI  = 7;
    localparam int              LSD_GAIN_BITS    = 7;
    localparam logic [6:0]      LSD_GAIN_RESET   = 7'h7F;
    localparam logic [1:0]      LSD_SWITCH_CYC   = 2'h2;
    localparam logic [1:0]      LSD_LOW_LOAD     = 2'h2;
    localparam logic [1:0]      LSD_LOW_MAX      = 2'h3;
    localparam int              LSD_GAIN_DEN     = 288;
    localparam int              LSD_REF_UV       = 1417500;
    localparam int              LSD_CURRENT_MULT = 15;
    localparam int              LSD_CLK_NS       = 40;
    localparam int              LSD_SETTLE_NS    = 2000;
    localparam int              LSD_SETTLE_CYC   = (LSD_SETTLE_NS + LSD_CLK_NS - 1) / LSD_CLK_NS;
    localparam logic [5:0]      LSD_SETTLE_CNT   = 6'(LSD_SETTLE_CYC);

    typedef enum logic {
        LSD_NORMAL,
        LSD_SPECIAL
    } lsd_mode_t;

    // Gain is returned as a numerator over LSD_GAIN_DEN; code is {mantissa bits 7..2, band bit 1}.
    function automatic logic [8:0] lsd_gain_num(input logic [6:0] code);
        logic [5:0] mant;
        logic [8:0] band;
        mant = {code[1], code[2], code[3], code[4], code[5], code[6]};
        band = code[0] ? 9'h003 : 9'h001;
        return 9'(band * (9'h020 + {3'h0, mant}));
    endfunction

endpackage

// [logic/lsd_pulse_detect.sv]
// Detector of the one-clock low pulse on the enable line that starts a mode switch.
`timescale 1ns/1ps
module lsd_pulse_detect (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic enableSwitchDetectN,
    output logic      pulseSeen
);
    import lsd_pkg::*;

    typedef struct packed {
        logic [1:0] hist;
    } lsd_detect_t;

    lsd_detect_t st_q;
    lsd_detect_t st_d;

    always_comb begin
        st_d      = st_q;
        st_d.hist = {st_q.hist[0], enableSwitchDetectN};
    end

    // Reset history is low so a high line after power-on cannot fake a pulse.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pulseSeen = (st_q.hist == 2'h2) && enableSwitchDetectN;

endmodule // lsd_pulse_detect

// [logic/lsd_shift_reg.sv]
// Sixteen-stage shift register with a parallel load port for captured status.
`timescale 1ns/1ps
module lsd_shift_reg (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic                    serialIn,
    input  wire logic                    loadPar,
    input  wire logic [LSD_CHANNELS-1:0] parIn,
    output logic      [LSD_CHANNELS-1:0] bits,
    output logic                         serialOut
);
    import lsd_pkg::*;

    typedef struct packed {
        logic [LSD_CHANNELS-1:0] bits;
    } lsd_shift_t;

    lsd_shift_t st_q;
    lsd_shift_t st_d;

    always_comb begin
        st_d = st_q;
        if (loadPar) begin
            st_d.bits = parIn;
        end else begin
            st_d.bits = {st_q.bits[LSD_CHANNELS-2:0], serialIn};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign bits      = st_q.bits;
    assign serialOut = st_q.bits[LSD_CHANNELS-1];

endmodule // lsd_shift_reg

// [logic/lsd_sink_ctrl.sv]
// Mode, latch and error-capture control of the sixteen-channel LED sink driver.
`timescale 1ns/1ps
module lsd_sink_ctrl (
    input  wire logic                             clk,
    input  wire logic                             resetn,
    input  wire logic                             serialIn,
    input  wire logic                             latchModeSelect,
    input  wire logic                             enableSwitchDetectN,
    input  wire logic [lsd_pkg::LSD_CHANNELS-1:0] errorStatus,
    output logic                                  serialOut,
    output logic      [lsd_pkg::LSD_CHANNELS-1:0] channelOn,
    output logic                                  specialMode,
    output logic                                  switching,
    output logic                                  detectActive,
    output logic                                  captureValid,
    output logic                                  bandSelect,
    output logic      [5:0]                       gainMantissa,
    output logic      [8:0]                       gainNumerator
);
    import lsd_pkg::*;

    typedef struct packed {
        lsd_mode_t               mode;
        logic [1:0]              swCnt;
        logic                    pendSpecial;
        logic [1:0]              lowCnt;
        logic [5:0]              settleCnt;
        logic [LSD_CHANNELS-1:0] outLatch;
        logic [6:0]              gain;
        logic [LSD_CHANNELS-1:0] chanOn;
        logic                    detect;
        logic                    capValid;
        logic [8:0]              gainNum;
    } lsd_core_t;

    lsd_core_t               st_q;
    lsd_core_t               st_d;
    logic                    pulseSeen;
    logic [LSD_CHANNELS-1:0] srBits;
    logic [LSD_CHANNELS-1:0] statusIn;
    logic                    oeLow;
    logic                    isSpecial;
    logic                    latchBlock;
    logic                    loadErr;

    lsd_pulse_detect u_detect (
        .clk                 (clk),
        .resetn              (resetn),
        .enableSwitchDetectN (enableSwitchDetectN),
        .pulseSeen           (pulseSeen)
    );

    lsd_shift_reg u_shift (
        .clk       (clk),
        .resetn    (resetn),
        .serialIn  (serialIn),
        .loadPar   (loadErr),
        .parIn     (statusIn),
        .bits      (srBits),
        .serialOut (serialOut)
    );

    assign oeLow      = !enableSwitchDetectN;
    assign isSpecial  = (st_q.mode == LSD_SPECIAL);
    // The pulse edge and both transition edges only select a mode, never latch.
    assign latchBlock = pulseSeen || (st_q.swCnt != 2'h0);
    // The first two low samples still shift, so a switch pulse never stalls the chain.
    assign loadErr    = isSpecial && oeLow && (st_q.lowCnt >= LSD_LOW_LOAD);
    // A channel that is switched off always reports zero, whatever the comparator says.
    assign statusIn   = errorStatus & st_q.chanOn;

    always_comb begin
        st_d = st_q;
        // Mode switch sequencing.
        if (pulseSeen) begin
            st_d.swCnt = LSD_SWITCH_CYC;
        end else if (st_q.swCnt == LSD_SWITCH_CYC) begin
            st_d.pendSpecial = latchModeSelect;
            st_d.swCnt       = 2'h1;
        end else if (st_q.swCnt == 2'h1) begin
            st_d.mode  = st_q.pendSpecial ? LSD_SPECIAL : LSD_NORMAL;
            st_d.swCnt = 2'h0;
        end
        // Consecutive low samples and low time on the enable line.
        if (oeLow) begin
            st_d.lowCnt    = (st_q.lowCnt == LSD_LOW_MAX) ? LSD_LOW_MAX : st_q.lowCnt + 2'h1;
            st_d.settleCnt = (st_q.settleCnt == LSD_SETTLE_CNT) ? LSD_SETTLE_CNT : st_q.settleCnt + 6'h01;
        end else begin
            st_d.lowCnt    = 2'h0;
            st_d.settleCnt = 6'h00;
        end
        // Latch strobe goes to the configuration latch in Special mode.
        if (latchModeSelect && !latchBlock) begin
            if (isSpecial) begin
                st_d.gain = srBits[LSD_CFG_MANT_HI:LSD_CFG_BAND_BIT];
            end else begin
                st_d.outLatch = srBits;
            end
        end
        st_d.chanOn = oeLow ? st_q.outLatch : '0;
        st_d.detect = isSpecial && oeLow;
        if (loadErr) begin
            st_d.capValid = (st_q.settleCnt >= LSD_SETTLE_CNT);
        end
        st_d.gainNum = lsd_gain_num(st_d.gain);
    end

    // Reset stands in for power-on; the gain code returns to full scale.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q             <= '0;
            st_q.mode        <= LSD_NORMAL;
            st_q.gain        <= LSD_GAIN_RESET;
            st_q.gainNum     <= lsd_gain_num(LSD_GAIN_RESET);
        end else begin
            st_q <= st_d;
        end
    end

    assign channelOn     = st_q.chanOn;
    assign specialMode   = isSpecial;
    assign switching     = (st_q.swCnt != 2'h0);
    assign detectActive  = st_q.detect;
    assign captureValid  = st_q.capValid;
    assign bandSelect    = st_q.gain[0];
    assign gainMantissa  = {st_q.gain[1], st_q.gain[2], st_q.gain[3], st_q.gain[4], st_q.gain[5], st_q.gain[6]};
    assign gainNumerator = st_q.gainNum;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    mode_enter_a: assert property ((pulseSeen ##1 latchModeSelect) |-> ##2 specialMode)
        else $error("Special mode not entered after switch pulse with latch high.");
    mode_stay_a: assert property ((pulseSeen ##1 !latchModeSelect) |-> ##2 !specialMode)
        else $error("Normal mode not selected after switch pulse with latch low.");
    latch_hold_a: assert property (pulseSeen |=> ($stable(st_q.outLatch) && $stable(st_q.gain))[*3])
        else $error("A latch changed during the mode switch window.");
    out_latch_a: assert property ((!isSpecial && latchModeSelect && !latchBlock) |=> st_q.outLatch == $past(srBits))
        else $error("Normal mode latch did not copy the shift register.");
    chan_drive_a: assert property (1'b1 |=> channelOn == ($past(oeLow) ? $past(st_q.outLatch) : '0))
        else $error("Channel drive does not follow enable and output latch.");
    err_load_a: assert property (loadErr |=> srBits == $past(errorStatus & st_q.chanOn))
        else $error("Status bits were not loaded into the shift register.");
    shift_step_a: assert property (!loadErr |=> srBits == {$past(srBits[14:0]), $past(serialIn)})
        else $error("Shift register did not advance by one stage.");
    cfg_write_a: assert property ((isSpecial && latchModeSelect && !latchBlock) |=> st_q.gain == $past(srBits[7:1]))
        else $error("Configuration latch not written from the shift register.");
    cfg_keep_a: assert property (!(isSpecial && latchModeSelect && !latchBlock) |=> $stable(st_q.gain))
        else $error("Configuration latch changed without a write.");
    capture_gap_a: assert property ((isSpecial && $fell(enableSwitchDetectN)) |-> !loadErr ##1 !loadErr)
        else $error("Status loaded before the third low sample.");

    special_entry_c: cover property (pulseSeen ##1 latchModeSelect ##2 specialMode);
    error_load_c: cover property (loadErr ##1 !oeLow);
    cfg_write_c: cover property (isSpecial && latchModeSelect && !latchBlock);
    normal_latch_c: cover property (!isSpecial && latchModeSelect && !latchBlock ##1 oeLow);

endmodule // lsd_sink_ctrl

// [verification/lsd_host_model.sv]
// Behavioural system controller that drives the serial and control lines of the sink driver.
`timescale 1ns/1ps
module lsd_host_model (
    input  wire logic clk,
    output logic      serialIn,
    output logic      latchModeSelect,
    output logic      enableSwitchDetectN
);
    initial begin
        serialIn = 1'b0;
        latchModeSelect = 1'b0;
        enableSwitchDetectN = 1'b1;
    end

    task automatic drive(input logic si, input logic le, input logic oeN);
        @(posedge clk);
        serialIn <= si;
        latchModeSelect <= le;
        enableSwitchDetectN <= oeN;
    endtask

    // The first bit sent ends in the last stage, so the word sits in the register as written.
    task automatic shiftWord(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) drive(w[i], 1'b0, 1'b1);
    endtask

    task automatic latchWord();
        drive(1'b0, 1'b1, 1'b1);
    endtask

    // High, low, high on the enable line, then the mode level held over the third to fifth edges.
    task automatic modeSwitch(input logic le);
        drive(1'($urandom), 1'b0, 1'b1);
        drive(1'($urandom), 1'b0, 1'b0);
        repeat (3) drive(1'($urandom), le, 1'b1);
        drive(1'b0, 1'b0, 1'b1);
    endtask

    // Serial input is held still during detection, and low is kept for n cycles before the line returns high.
    task automatic detect(input int n);
        repeat (n) drive(1'b1, 1'b0, 1'b0);
        drive(1'b1, 1'b0, 1'b1);
    endtask
endmodule // lsd_host_model

// [verification/lsd_sink_ctrl_tb_top.sv]
// Self-checking testbench of the sink driver control logic against a cycle model.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module lsd_sink_ctrl_tb_top;
    import lsd_pkg::*;
    logic        clk;
    logic        resetn;
    logic        serialIn;
    logic        latchModeSelect;
    logic        enableSwitchDetectN;
    logic [15:0] errorStatus;
    logic        serialOut;
    logic [15:0] channelOn;
    logic        specialMode;
    logic        switching;
    logic        detectActive;
    logic        captureValid;
    logic        bandSelect;
    logic [5:0]  gainMantissa;
    logic [8:0]  gainNumerator;
    int          fail_count = 0;
    int          num_checks = 0;
    logic [15:0] mSr, mLat, mOn, nSr;
    logic [6:0]  mCfg;
    logic [1:0]  mHist;
    logic        mMode, mPend, mDet, det, mCap;
    int          mCnt, mLow;

    lsd_host_model u_host (
        .clk                 (clk),
        .serialIn            (serialIn),
        .latchModeSelect     (latchModeSelect),
        .enableSwitchDetectN (enableSwitchDetectN)
    );

    lsd_sink_ctrl u_lsd_sink_ctrl (
        .clk                 (clk),
        .resetn              (resetn),
        .serialIn            (serialIn),
        .latchModeSelect     (latchModeSelect),
        .enableSwitchDetectN (enableSwitchDetectN),
        .errorStatus         (errorStatus),
        .serialOut           (serialOut),
        .channelOn           (channelOn),
        .specialMode         (specialMode),
        .switching           (switching),
        .detectActive        (detectActive),
        .captureValid        (captureValid),
        .bandSelect          (bandSelect),
        .gainMantissa        (gainMantissa),
        .gainNumerator       (gainNumerator)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Cycle model: inputs are read at the edge before the host's updates land.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {mSr, mLat, mOn, mHist, mMode, mPend, mDet, mCnt, mLow} = '0;
            mCap = 1'b0;
            mCfg = 7'h7F;
        end else begin
            det = (mHist == 2'h2) && enableSwitchDetectN;
            nSr = (mMode && !enableSwitchDetectN && mLow >= 2) ? (errorStatus & mOn)
                                                                : {mSr[14:0], serialIn};
            // Status loads from the third low sample; it is valid only after 2 us of low time, counted as 50 earlier low samples.
            if (mMode && !enableSwitchDetectN && mLow >= 2) mCap = (mLow >= 50);
            // Channels follow the latch as it stood before this edge.
            mOn = enableSwitchDetectN ? 16'h0 : mLat;
            if (latchModeSelect && !det && mCnt == 0) begin
                if (mMode) mCfg = mSr[7:1];
                else mLat = mSr;
            end
            mDet = mMode && !enableSwitchDetectN;
            mSr = nSr;
            if (mCnt == 2) mMode = mPend;
            if (mCnt == 1) mPend = latchModeSelect;
            mCnt = det ? 1 : (mCnt == 1 ? 2 : 0);
            mLow = enableSwitchDetectN ? 0 : mLow + 1;
            mHist = {mHist[0], enableSwitchDetectN};
        end
    end

    always @(negedge clk) begin
        if (resetn === 1'b1) begin
            `CHK("specialMode", mMode, specialMode)
            `CHK("switching", (mCnt != 0), switching)
            `CHK("channelOn", mOn, channelOn)
            `CHK("detectActive", mDet, detectActive)
            `CHK("captureValid", mCap, captureValid)
            `CHK("serialOut", mSr[15], serialOut)
            `CHK("bandSelect", mCfg[0], bandSelect)
            `CHK("gainMantissa", {mCfg[1], mCfg[2], mCfg[3], mCfg[4], mCfg[5], mCfg[6]}, gainMantissa)
            `CHK("gainNumerator", 9'((1 + 2 * mCfg[0]) * (32 + {mCfg[1], mCfg[2], mCfg[3], mCfg[4], mCfg[5], mCfg[6]})), gainNumerator)
        end
    end

    // Status inputs change every cycle so a capture on the wrong edge shows up.
    always @(posedge clk) errorStatus <= 16'($urandom);

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("BAD watchdog expired");
        stop_test();
    end

    initial begin
        resetn = 1'b0;
        errorStatus = 16'h0;
        void'($urandom(32'h57BD));
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        u_host.shiftWord(16'($urandom));
        u_host.latchWord();
        repeat (5) u_host.drive(1'b0, 1'b0, 1'b0);
        $display("test normal latch and enable done");
        repeat (2) u_host.drive(1'b0, 1'b0, 1'b0);
        repeat (3) u_host.drive(1'b1, 1'b1, 1'b1);
        $display("test wide low pulse done");
        u_host.modeSwitch(1'b1);
        for (int k = 0; k < 4; k++) begin
            u_host.shiftWord(16'($urandom));
            u_host.latchWord();
        end
        $display("test gain programming done");
        u_host.detect(52);
        u_host.shiftWord(16'($urandom));
        u_host.detect(3);
        u_host.shiftWord(16'hFFFF);
        $display("test status capture done");
        u_host.modeSwitch(1'b0);
        u_host.modeSwitch(1'b0);
        repeat (3) u_host.drive(1'b0, 1'b0, 1'b0);
        $display("test return to normal done");
        stop_test();
    end
endmodule // lsd_sink_ctrl_tb_top
